// ---- verilog/dual_tap_consts.svh ----
// constants for the dual-tap pixel output sequencer
`ifndef DUAL_TAP_CONSTS_SVH
`define DUAL_TAP_CONSTS_SVH

`define PIX_BITS     10
`define LANE_BITS    8
`define COL_W        11
`define MAX_COLS     11'h500
`define MAX_ROWS     11'h400
`define COL_STEP     11'h00a
`define LEAD_CYCLES  5'h05
`define LINE_GAP     5'h14
`define FRAME_GAP    5'h0f
`define FIFO_DEPTH   16

`endif

// ---- verilog/dual_tap_pkg.sv ----
// types shared by the dual-tap pixel output sequencer
package dual_tap_pkg;
`include "dual_tap_consts.svh"

  typedef struct packed {
    logic                  sof;
    logic                  eol;
    logic [`PIX_BITS-1:0]  pix1;
    logic [`PIX_BITS-1:0]  pix0;
  } pair_word_t;

  typedef struct packed {
    logic [`COL_W-1:0] skip_pairs;
    logic [`COL_W-1:0] end_pair;
    logic [`COL_W-1:0] rows;
    logic [1:0]        shift;
  } roi_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_LEAD = 5'b00010,
    ST_LINE = 5'b00100,
    ST_LGAP = 5'b01000,
    ST_FGAP = 5'b10000
  } seq_state_t;

endpackage

// ---- verilog/async_pair_fifo.sv ----
// dual-clock fifo with gray-coded pointers
`timescale 1ns/1ps
module async_pair_fifo #(
  parameter int WIDTH = 22,
  parameter int DEPTH = 16
) (
  input  wire logic             wr_clk_in,
  input  wire logic             wr_rst_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  input  wire logic             rd_clk_in,
  input  wire logic             rd_rst_in,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_reg, rbin_reg;
  logic [AW:0]      wgray_reg, rgray_reg;
  logic [AW:0]      rg_meta_reg, rg_sync_reg;
  logic [AW:0]      wg_meta_reg, wg_sync_reg;
  logic [AW:0]      wbin_next, rbin_next;
  logic             push, pop;

  // ------------------------------------------------------------
  // write side
  // ------------------------------------------------------------
  assign wr_ready_out = wgray_reg != {~rg_sync_reg[AW:AW-1], rg_sync_reg[AW-2:0]};
  assign push         = wr_valid_in && wr_ready_out;
  assign wbin_next    = wbin_reg + (AW+1)'(push);

  always_ff @(posedge wr_clk_in) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= wr_data_in;
    end
  end

  always_ff @(posedge wr_clk_in) begin
    if (wr_rst_in) begin
      wbin_reg    <= '0;
      wgray_reg   <= '0;
      rg_meta_reg <= '0;
      rg_sync_reg <= '0;
    end else begin
      wbin_reg    <= wbin_next;
      wgray_reg   <= bin2gray(wbin_next);
      rg_meta_reg <= rgray_reg;
      rg_sync_reg <= rg_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // read side
  // ------------------------------------------------------------
  assign rd_valid_out = rgray_reg != wg_sync_reg;
  assign rd_data_out  = mem[rbin_reg[AW-1:0]];
  assign pop          = rd_valid_out && rd_ready_in;
  assign rbin_next    = rbin_reg + (AW+1)'(pop);

  always_ff @(posedge rd_clk_in) begin
    if (rd_rst_in) begin
      rbin_reg    <= '0;
      rgray_reg   <= '0;
      wg_meta_reg <= '0;
      wg_sync_reg <= '0;
    end else begin
      rbin_reg    <= rbin_next;
      rgray_reg   <= bin2gray(rbin_next);
      wg_meta_reg <= wgray_reg;
      wg_sync_reg <= wg_meta_reg;
    end
  end
endmodule

// ---- verilog/dual_tap_pixel_output.sv ----
// dual-tap pixel output sequencer: sensor pairs in, two 8-bit lanes with markers out
// Functional notes
// - launch lanes and markers on rising edges
// - two 8-bit pixels per clock
// - largest frame 1280 by 1024
// - full line is 640 valid cycles
// - start column must be ten-k plus one
// - width must be multiple of ten
// - rows top first, columns left to right
// - lanes meaningful only while line marker high
// - cut 10-bit sample to 8 by shift
// - both markers low when not sending
// - capture and send may overlap or not
// - line rises five cycles after frame; later when the region skips columns
// - even pixel lane0, odd pixel lane1
// - twenty low cycles between lines
// - frame marker falls with last line
// - frame marker low at least fifteen cycles
// - single link at 50 MHz pixel clock
// - region sends fewer pixels than full
`timescale 1ns/1ps
`include "dual_tap_consts.svh"
module dual_tap_pixel_output #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  input  wire logic                     mclk_in,
  input  wire logic                     reset_in,
  input  wire logic                     sensor_clk_in,
  input  wire dual_tap_pkg::pair_word_t sensor_word_in,
  input  wire logic                     sensor_valid_in,
  output logic                          sensor_ready_out,
  input  wire logic [`COL_W-1:0]        roi_start_col_in,
  input  wire logic [`COL_W-1:0]        roi_width_in,
  input  wire logic [`COL_W-1:0]        roi_height_in,
  input  wire logic [1:0]               shift_sel_in,
  output logic [`LANE_BITS-1:0]         lane0_out,
  output logic [`LANE_BITS-1:0]         lane1_out,
  output logic                          frame_marker_out,
  output logic                          line_marker_out,
  output logic                          cfg_rejected_out,
  output logic                          underrun_out
);
  import dual_tap_pkg::*;

  localparam logic [`COL_W-1:0] END_FULL  = `COL_W'(`MAX_COLS / 2 - 1);
  localparam logic [4:0]        LEAD_LAST = 5'(`LEAD_CYCLES - 2);
  localparam logic [4:0]        LGAP_LAST = 5'(`LINE_GAP - 1);
  localparam logic [4:0]        FGAP_LAST = 5'(`FRAME_GAP - 1);
  localparam roi_cfg_t          CFG_RST   = '{skip_pairs: '0, end_pair: END_FULL,
                                              rows: `MAX_ROWS, shift: 2'h0};

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic cfg_ok(input logic [`COL_W-1:0] off,
                                  input logic [`COL_W-1:0] start,
                                  input logic [`COL_W-1:0] width,
                                  input logic [`COL_W-1:0] height);
    logic [`COL_W:0] span;
    span   = {1'b0, off} + {1'b0, width};
    cfg_ok = (start == '0 || off % `COL_STEP == '0)
          && width != '0 && width % `COL_STEP == '0
          && span <= {1'b0, `MAX_COLS}
          && height != '0 && height <= `MAX_ROWS;
  endfunction

  // shifts above zero saturate rather than wrap when high bits are set
  function automatic logic [`LANE_BITS-1:0] pix_cut(input logic [`PIX_BITS-1:0] s,
                                                    input logic [1:0]           sh);
    case (sh)
      2'h0:    pix_cut = s[9:2];
      2'h1:    pix_cut = s[9] ? 8'hff : s[8:1];
      default: pix_cut = (|s[9:8]) ? 8'hff : s[7:0];
    endcase
  endfunction

  // ------------------------------------------------------------
  // sensor-domain reset and crossing fifo
  // ------------------------------------------------------------
  logic s_rst_meta_reg;
  logic s_rst_reg;

  always_ff @(posedge sensor_clk_in) begin
    s_rst_meta_reg <= reset_in;
    s_rst_reg      <= s_rst_meta_reg;
  end

  logic [$bits(pair_word_t)-1:0] head_bits;
  pair_word_t                    head_w;
  logic                          head_valid;
  logic                          pop;

  // capture runs ahead of output until the fifo fills; sensor_ready_out then holds it back
  async_pair_fifo #(
    .WIDTH ($bits(pair_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .wr_clk_in    (sensor_clk_in),
    .wr_rst_in    (s_rst_reg),
    .wr_data_in   (sensor_word_in),
    .wr_valid_in  (sensor_valid_in),
    .wr_ready_out (sensor_ready_out),
    .rd_clk_in    (mclk_in),
    .rd_rst_in    (reset_in),
    .rd_data_out  (head_bits),
    .rd_valid_out (head_valid),
    .rd_ready_in  (pop)
  );

  assign head_w = pair_word_t'(head_bits);

  // ------------------------------------------------------------
  // region decode
  // ------------------------------------------------------------
  logic [`COL_W-1:0] start_off;
  logic [`COL_W-1:0] new_end;
  logic              new_ok;
  roi_cfg_t          new_cfg;

  assign start_off = (roi_start_col_in == '0) ? '0 : roi_start_col_in - `COL_W'(1);
  assign new_end   = `COL_W'((start_off + roi_width_in) >> 1) - `COL_W'(1);
  assign new_ok    = cfg_ok(start_off, roi_start_col_in, roi_width_in, roi_height_in);
  assign new_cfg   = '{skip_pairs: start_off >> 1, end_pair: new_end,
                       rows: roi_height_in, shift: shift_sel_in};

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  seq_state_t        state_reg, state_next;
  roi_cfg_t          cfg_reg, cfg_next;
  logic [4:0]        cnt_reg, cnt_next;
  logic [`COL_W-1:0] col_reg, col_next;
  logic [`COL_W-1:0] row_reg, row_next;
  logic              tail_reg, tail_next;
  logic              frame_reg, frame_next;
  logic              line_reg, line_next;
  logic              reject_next, underrun_next;
  logic [7:0]        lane0_reg, lane1_reg;
  logic              reject_reg, underrun_reg;

  logic sof_head, in_skip, at_skip, last_pair, last_row;
  logic idle_like, prep, cnt_done, ready_go;

  assign sof_head  = head_valid && head_w.sof;
  assign in_skip   = col_reg < cfg_reg.skip_pairs;
  assign at_skip   = col_reg == cfg_reg.skip_pairs;
  assign last_pair = col_reg == cfg_reg.end_pair;
  assign last_row  = row_reg == cfg_reg.rows - `COL_W'(1);
  assign idle_like = state_reg == ST_IDLE || state_reg == ST_FGAP;
  assign prep      = state_reg == ST_LEAD || state_reg == ST_LGAP;
  assign cnt_done  = (state_reg == ST_LEAD) ? cnt_reg == LEAD_LAST : cnt_reg == LGAP_LAST;
  assign ready_go  = cnt_done && !tail_reg && at_skip && head_valid;

  // columns outside the region are drained without output
  assign pop = (idle_like && head_valid && !head_w.sof)
            || (prep && head_valid && (tail_reg || in_skip))
            || (state_reg == ST_LINE && head_valid);

  always_comb begin
    state_next    = state_reg;
    cfg_next      = cfg_reg;
    cnt_next      = cnt_reg;
    col_next      = col_reg;
    row_next      = row_reg;
    tail_next     = tail_reg;
    reject_next   = 1'b0;
    underrun_next = 1'b0;
    if (pop) begin
      col_next = head_w.eol ? '0 : col_reg + `COL_W'(1);
      if (head_w.eol) begin
        tail_next = 1'b0;
      end
    end
    case (state_reg)
      ST_IDLE: begin
        if (sof_head) begin
          state_next  = ST_LEAD;
          cnt_next    = '0;
          col_next    = '0;
          row_next    = '0;
          tail_next   = 1'b0;
          cfg_next    = new_ok ? new_cfg : cfg_reg;
          reject_next = !new_ok;
        end
      end
      ST_LEAD, ST_LGAP: begin
        cnt_next = cnt_done ? cnt_reg : cnt_reg + 5'h01;
        if (ready_go) begin
          state_next = ST_LINE;
        end
      end
      ST_LINE: begin
        underrun_next = !head_valid;
        if (pop && last_pair) begin
          tail_next = !head_w.eol;
          cnt_next  = '0;
          if (last_row) begin
            state_next = ST_FGAP;
          end else begin
            state_next = ST_LGAP;
            row_next   = row_reg + `COL_W'(1);
          end
        end
      end
      ST_FGAP: begin
        cnt_next = cnt_reg + 5'h01;
        if (cnt_reg == FGAP_LAST) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // frame stays up through the cycle carrying the last pair
  assign frame_next = state_next == ST_LEAD || state_next == ST_LINE
                   || state_next == ST_LGAP || state_reg == ST_LINE;
  assign line_next  = state_reg == ST_LINE && head_valid;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_reg <= ST_IDLE;
      cfg_reg   <= CFG_RST;
      cnt_reg   <= '0;
      col_reg   <= '0;
      row_reg   <= '0;
      tail_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg   <= cfg_next;
      cnt_reg   <= cnt_next;
      col_reg   <= col_next;
      row_reg   <= row_next;
      tail_reg  <= tail_next;
    end
  end

  // ------------------------------------------------------------
  // output registers, launched on the pixel clock edge
  // ------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      frame_reg    <= 1'b0;
      line_reg     <= 1'b0;
      reject_reg   <= 1'b0;
      underrun_reg <= 1'b0;
    end else begin
      frame_reg    <= frame_next;
      line_reg     <= line_next;
      reject_reg   <= reject_next;
      underrun_reg <= underrun_next;
    end
  end

  // lanes only move with a valid pair, so idle cycles repeat the last data
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      lane0_reg <= 8'h00;
      lane1_reg <= 8'h00;
    end else if (line_next) begin
      lane0_reg <= pix_cut(head_w.pix0, cfg_reg.shift);
      lane1_reg <= pix_cut(head_w.pix1, cfg_reg.shift);
    end
  end

  assign lane0_out        = lane0_reg;
  assign lane1_out        = lane1_reg;
  assign frame_marker_out = frame_reg;
  assign line_marker_out  = line_reg;
  assign cfg_rejected_out = reject_reg;
  assign underrun_out     = underrun_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [5:0]        line_lo_cnt;
  logic [4:0]        frame_lo_cnt;
  logic [`COL_W-1:0] line_hi_cnt;
  logic              gap_seen, had_frame;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      line_lo_cnt  <= '0;
      frame_lo_cnt <= '0;
      line_hi_cnt  <= '0;
      gap_seen     <= 1'b0;
      had_frame    <= 1'b0;
    end else begin
      line_lo_cnt  <= line_reg ? '0 : line_lo_cnt + 6'(frame_reg && line_lo_cnt != 6'h3f);
      frame_lo_cnt <= frame_reg ? '0 : frame_lo_cnt + 5'(frame_lo_cnt != 5'h1f);
      line_hi_cnt  <= line_reg ? line_hi_cnt + `COL_W'(1) : '0;
      gap_seen     <= frame_reg && (gap_seen || line_reg);
      had_frame    <= had_frame || frame_reg;
    end
  end

  sequence lead_quiet_s;
    !line_reg [*5];
  endsequence

  sequence frame_close_s;
    !line_reg && $past(line_reg);
  endsequence

  lead_delay_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(frame_reg) && cfg_reg.skip_pairs == '0 |-> lead_quiet_s)
    else $error("line marker rose inside the frame lead");

  // a line resuming after an empty fifo is not the start of a new line
  line_gap_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(line_reg) && gap_seen && !$past(underrun_reg) |-> line_lo_cnt >= 6'(`LINE_GAP))
    else $error("line gap shorter than required");

  frame_close_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $fell(frame_reg) |-> frame_close_s)
    else $error("frame marker did not fall with line marker");

  frame_gap_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $rose(frame_reg) && had_frame |-> frame_lo_cnt >= 5'(`FRAME_GAP))
    else $error("frame gap too short");

  idle_low_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !frame_reg |-> !line_reg)
    else $error("line marker high outside a frame");

  line_length_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    line_reg |-> line_hi_cnt <= cfg_reg.end_pair - cfg_reg.skip_pairs)
    else $error("line longer than region width");

  lane_hold_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    !line_reg |-> $stable(lane0_reg) && $stable(lane1_reg))
    else $error("lanes changed with line marker low");

  column_order_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    state_reg == ST_LINE && pop && !last_pair && !head_w.eol
    |=> col_reg == $past(col_reg) + `COL_W'(1))
    else $error("column did not advance by one pair");

  roi_reject_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    state_reg == ST_IDLE && sof_head && !new_ok |=> cfg_rejected_out && $stable(cfg_reg))
    else $error("bad region was accepted");

  shift_cut_a: assert property (@(posedge mclk_in) disable iff (reset_in)
    $past(line_next) && cfg_reg.shift == 2'h0 |-> lane0_reg == $past(head_w.pix0[9:2]))
    else $error("lane0 does not carry the top eight bits");
endmodule

// ---- sim/grabber_model.sv ----
// frame grabber receiver model: captures lane pixels and measures marker timing
`timescale 1ns/1ps
module grabber_model (
  input wire logic       mclk_in,
  input wire logic       reset_in,
  input wire logic       clear_in,
  input wire logic [7:0] lane0_in,
  input wire logic [7:0] lane1_in,
  input wire logic       frame_marker_in,
  input wire logic       line_marker_in
);
  logic [7:0] mem [0:4095];
  int         n_pix, n_lines, n_frames, lead, lead_cnt, hi_cnt, gap_cnt, low_cnt;
  int         len_min, len_max, lgap_min, fgap_min, bad_edge;
  logic       fm_q, lm_q, got_line, seen;

  // ------------------------------
  // sampling on the launch edge
  // ------------------------------
  always @(posedge mclk_in) begin
    if (reset_in || clear_in) begin
      n_pix = 0;
      n_lines = 0;
      n_frames = 0;
      lead = 0;
      lead_cnt = 0;
      hi_cnt = 0;
      gap_cnt = 0;
      low_cnt = 0;
      len_min = 1 << 30;
      len_max = 0;
      lgap_min = 1 << 30;
      fgap_min = 1 << 30;
      bad_edge = 0;
      got_line = 1'b0;
      seen = 1'b0;
      fm_q = frame_marker_in;
      lm_q = line_marker_in;
    end else begin
      if (line_marker_in) begin  // lane bytes outside the line marker are ignored
        mem[n_pix % 4096] = lane0_in;
        mem[(n_pix + 1) % 4096] = lane1_in;
        n_pix += 2;
        hi_cnt++;
      end
      if (frame_marker_in && !fm_q) begin
        if (seen && low_cnt < fgap_min) fgap_min = low_cnt;
        lead_cnt = 1;
        got_line = 1'b0;
        low_cnt = 0;
      end else if (frame_marker_in && !got_line && !line_marker_in) begin
        lead_cnt++;
      end
      if (line_marker_in && !lm_q) begin
        if (got_line && gap_cnt < lgap_min) lgap_min = gap_cnt;
        if (!got_line) lead = lead_cnt;
        got_line = 1'b1;
        n_lines++;
      end
      if (!line_marker_in && lm_q) begin
        if (hi_cnt < len_min) len_min = hi_cnt;
        if (hi_cnt > len_max) len_max = hi_cnt;
        hi_cnt = 0;
        gap_cnt = 0;
      end
      if (frame_marker_in && !line_marker_in) gap_cnt++;
      if (!frame_marker_in && fm_q) begin
        if (!(lm_q && !line_marker_in)) bad_edge++;
        n_frames++;
        seen = 1'b1;
      end
      if (line_marker_in && !frame_marker_in) bad_edge++;
      if (!frame_marker_in) low_cnt++;
      fm_q = frame_marker_in;
      lm_q = line_marker_in;
    end
  end
endmodule

// ---- sim/dual_tap_pixel_output_tb.sv ----
// self-checking bench for the dual-tap pixel output sequencer
`timescale 1ns/1ps
`include "dual_tap_consts.svh"
module dual_tap_pixel_output_tb;
  import dual_tap_pkg::*;
  logic              mclk = 1'b0;
  logic              sclk = 1'b0;
  logic              rst = 1'b1;
  logic              clr = 1'b0;
  logic              valid = 1'b0;
  pair_word_t        word = '0;
  logic [`COL_W-1:0] start_col = '0;
  logic [`COL_W-1:0] width = 11'h500;
  logic [`COL_W-1:0] height = 11'h400;
  logic [1:0]        shift = '0;
  logic              ready, fm, lm, rej, und;
  logic [7:0]        l0, l1;
  int                fail_count = 0;
  int                n_compared = 0;
  int                n_rej = 0;
  int                n_und = 0;
  int                n_wait = 0;
  int                cycles = 0;

  always #10 mclk = ~mclk;
  initial begin
    #3.3;
    forever #7.5 sclk = ~sclk;
  end

  dual_tap_pixel_output #(.FIFO_DEPTH(`FIFO_DEPTH)) dut (
    .mclk_in          (mclk),
    .reset_in         (rst),
    .sensor_clk_in    (sclk),
    .sensor_word_in   (word),
    .sensor_valid_in  (valid),
    .sensor_ready_out (ready),
    .roi_start_col_in (start_col),
    .roi_width_in     (width),
    .roi_height_in    (height),
    .shift_sel_in     (shift),
    .lane0_out        (l0),
    .lane1_out        (l1),
    .frame_marker_out (fm),
    .line_marker_out  (lm),
    .cfg_rejected_out (rej),
    .underrun_out     (und)
  );

  grabber_model grab (
    .mclk_in         (mclk),
    .reset_in        (rst),
    .clear_in        (clr),
    .lane0_in        (l0),
    .lane1_in        (l1),
    .frame_marker_in (fm),
    .line_marker_in  (lm)
  );

  // ------------------------------
  // helpers
  // ------------------------------
  // the 97 step makes the first ten columns cross every saturation threshold
  function automatic logic [9:0] pv(int r, int c);
    return 10'(c * 97 + r * 3);
  endfunction

  function automatic logic [7:0] cut(logic [9:0] v, logic [1:0] s);
    if (s == 2'h0) return v[9:2];
    if (s == 2'h1) return v[9] ? 8'hff : v[8:1];
    return (v[9:8] != 2'h0) ? 8'hff : v[7:0];
  endfunction

  task automatic report_and_stop();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (rej === 1'b1) n_rej++;
    if (und === 1'b1) n_und++;
    if (cycles == 60000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk_num(string what, int exp, int got);
    n_compared++;
    if (exp !== got) begin
      fail_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (exp !== got) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set_cfg(int s, int w, int h, logic [1:0] sh);
    @(posedge mclk);
    start_col <= 11'(s);
    width <= 11'(w);
    height <= 11'(h);
    shift <= sh;
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    n_rej = 0;
    n_und = 0;
    n_wait = 0;
  endtask

  // the word is held until ready is seen high at the falling edge before the taking edge
  task automatic send_frame(int rows, bit slow);
    logic ok;
    @(posedge sclk);
    for (int r = 0; r < rows; r++) begin
      for (int p = 0; p < 640; p++) begin
        word <= {(r == 0 && p == 0), (p == 639), pv(r, 2 * p + 1), pv(r, 2 * p)};
        valid <= 1'b1;
        do begin
          @(negedge sclk);
          ok = ready;
          if (ok !== 1'b1) n_wait++;
          @(posedge sclk);
        end while (ok !== 1'b1);
        if (slow) begin
          valid <= 1'b0;
          word <= ~word;
          @(posedge sclk);
        end
      end
    end
    valid <= 1'b0;
    word <= ~word;
  endtask

  task automatic wait_frames(int k);
    for (int i = 0; i < 20000 && grab.n_frames < k; i++) @(posedge mclk);
    chk_num("frames", k, grab.n_frames);
    repeat (2) @(posedge mclk);
  endtask

  task automatic chk_pix(int off, int w, int rows, logic [1:0] sh);
    chk_num("pixel count", w * rows, grab.n_pix);
    for (int r = 0; r < rows; r++)
      for (int c = 0; c < w; c++)
        chk_byte("pixel", cut(pv(r, off + c), sh), grab.mem[r * w + c]);
  endtask

  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_full();
    set_cfg(0, 1280, 2, 2'h0);
    send_frame(2, 0);
    wait_frames(1);
    chk_num("lead", 5, grab.lead);
    chk_num("line length min", 640, grab.len_min);
    chk_num("line length max", 640, grab.len_max);
    chk_num("line gap", 20, grab.lgap_min);
    chk_num("lines", 2, grab.n_lines);
    chk_num("marker edges", 0, grab.bad_edge);
    chk_num("underruns", 0, n_und);
    chk_num("fifo refused", 1, int'(n_wait > 0));
    chk_pix(0, 1280, 2, 2'h0);
  endtask

  task automatic t_roi();
    set_cfg(11, 20, 3, 2'h1);
    send_frame(3, 0);
    wait_frames(1);
    chk_num("line length min", 10, grab.len_min);
    chk_num("line length max", 10, grab.len_max);
    chk_num("lines", 3, grab.n_lines);
    chk_num("line gap floor", 1, int'(grab.lgap_min >= 20));
    chk_pix(10, 20, 3, 2'h1);
  endtask

  task automatic t_shift();
    for (int s = 2; s < 4; s++) begin
      set_cfg(0, 10, 1, 2'(s));
      send_frame(1, 0);
      wait_frames(1);
      chk_num("lead", 5, grab.lead);
      chk_pix(0, 10, 1, 2'(s));
    end
  endtask

  // an illegal start or width must leave the 10-column one-row region in force
  task automatic t_reject();
    int bs [2] = '{5, 1};
    int bw [2] = '{20, 15};
    for (int i = 0; i < 2; i++) begin
      set_cfg(bs[i], bw[i], 2, 2'h0);
      send_frame(2, 0);
      wait_frames(1);
      chk_num("rejections", 1, n_rej);
      chk_num("line length", 5, grab.len_max);
      chk_num("lines", 1, grab.n_lines);
      chk_pix(0, 10, 1, 2'h3);
    end
  endtask

  task automatic t_b2b();
    set_cfg(0, 20, 1, 2'h0);
    send_frame(1, 0);
    send_frame(1, 0);
    wait_frames(2);
    chk_num("frame gap floor", 1, int'(grab.fgap_min >= 15));
    chk_num("pixel count", 40, grab.n_pix);
    chk_num("marker edges", 0, grab.bad_edge);
  endtask

  task automatic t_under();
    set_cfg(0, 1280, 1, 2'h0);
    send_frame(1, 1);
    wait_frames(1);
    chk_num("underrun seen", 1, int'(n_und > 0));
    chk_num("marker edges", 0, grab.bad_edge);
    chk_pix(0, 1280, 1, 2'h0);
  endtask

  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (8) @(posedge mclk);
    t_full();
    t_roi();
    t_shift();
    t_reject();
    t_b2b();
    t_under();
    report_and_stop();
  end
endmodule
